// ===== core/asg_top.sv
// address generation and address-space steering top
// assumes: one 200 MHz clock, synchronous active-high reset; bus,
// translation unit both run on SYS_CLK_I
`timescale 1ns/1ps
module asg_top
	import asg_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	// processor mode
	input wire logic PROT_MODE_I,
	input wire logic PAGING_I,
	// access request
	input wire logic REQ_VALID_I,
	input wire asg_kind_t REQ_KIND_I,
	input wire logic REQ_WR_I,
	input wire asg_size_t REQ_SIZE_I,
	input wire logic [DATA_W-1:0] REQ_WDATA_I,
	input wire logic [IO_PORT_W-1:0] REQ_PORT_I,
	input wire logic [COP_OFS_W-1:0] REQ_COP_OFS_I,
	output logic REQ_READY_O,
	// operand address
	input wire logic [GPR_N*DATA_W-1:0] GPR_FILE_I,
	input wire asg_amode_t AMODE_I,
	input wire logic [2:0] BASE_SEL_I,
	input wire logic [2:0] INDEX_SEL_I,
	input wire logic [1:0] INDEX_MULTIPLIER_I,
	input wire logic [ADDR_W-1:0] DISPLACEMENT_VALUE_I,
	input wire logic [SEG_W-1:0] SEG_VALUE_I,
	input wire logic [ADDR_W-1:0] SEG_BASE_I,
	// page translation
	output logic XLATE_REQ_O,
	output logic [PG_DIR_W-1:0] XLATE_DIR_O,
	output logic [PG_TBL_W-1:0] XLATE_TBL_O,
	output logic [PG_OFS_W-1:0] XLATE_OFS_O,
	input wire logic XLATE_ACK_I,
	input wire logic [ADDR_W-1:0] XLATE_PHYS_I,
	// system bus
	output logic BUS_CYC_O,
	output logic [ADDR_W-1:0] BUS_ADDR_O,
	output logic [3:0] BUS_BE_O,
	output logic BUS_MIO_O,
	output logic BUS_WR_O,
	output asg_size_t BUS_SIZE_O,
	output logic [DATA_W-1:0] BUS_WDATA_O,
	input wire logic BUS_DONE_I,
	input wire logic [DATA_W-1:0] BUS_RDATA_I,
	// completion
	output logic DONE_O,
	output logic FAULT_O,
	output logic OVERRUN_O,
	output logic [DATA_W-1:0] RDATA_O,
	output logic [ADDR_W-1:0] OFFSET_RESULT_O,
	output logic [CFG_REG_N*8-1:0] CFG_REGS_O
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_XLATE,
		ST_BUS
	} asg_state_t;

	typedef struct packed
	{
		asg_state_t st;
		logic ready;
		logic xreq;
		logic [ADDR_W-1:0] xlin;
		logic cyc;
		logic [ADDR_W-1:0] addr;
		logic [3:0] be;
		logic mio;
		logic wr;
		asg_size_t size;
		logic [DATA_W-1:0] wdata;
		logic done;
		logic fault;
		logic overrun;
		logic [DATA_W-1:0] rdata;
		logic [ADDR_W-1:0] ofs;
	} asg_top_st_t;

	localparam asg_top_st_t TOP_RST = '0;

	asg_top_st_t s;
	asg_top_st_t n;
	logic cfg_acc;
	logic cfg_internal;
	logic [7:0] cfg_rdata;
	logic [CFG_REG_N-1:0][7:0] cfg_regs;
	logic [REAL_W-1:0] real_addr;
	logic [ADDR_W-1:0] lin_addr;

	// ---------------------------------------------------------------
	// byte lanes: low byte at lowest address
	// ---------------------------------------------------------------
	function automatic logic [3:0] lanes(input asg_size_t sz,
		input logic [1:0] lo);
		logic [3:0] m;
		case (sz)
			SZ_BYTE: m = 4'h1;
			SZ_WORD: m = 4'h3;
			default: m = 4'hf;
		endcase
		lanes = 4'(m << lo);
	endfunction : lanes

	// ---------------------------------------------------------------
	// offset adder and configuration port
	// ---------------------------------------------------------------
	asg_ea_if ea_bus();

	assign ea_bus.gpr = GPR_FILE_I;
	assign ea_bus.amode = AMODE_I;
	assign ea_bus.base_sel = BASE_SEL_I;
	assign ea_bus.index_sel = INDEX_SEL_I;
	assign ea_bus.index_multiplier = INDEX_MULTIPLIER_I;
	assign ea_bus.displacement_value = DISPLACEMENT_VALUE_I;

	asg_offset_calc u_calc
	(
		.ea(ea_bus.calc)
	);

	assign cfg_acc = (s.st == ST_IDLE) && s.ready && REQ_VALID_I &&
		(REQ_KIND_I == K_IO);

	asg_cfg_port #(
		.REG_N(CFG_REG_N)
	) u_cfg
	(
		.clk_i(SYS_CLK_I),
		.rst_i(SYS_RST_I),
		.acc_i(cfg_acc),
		.wr_i(REQ_WR_I),
		.port_i(REQ_PORT_I),
		.wdata_i(REQ_WDATA_I[7:0]),
		.internal_o(cfg_internal),
		.rdata_o(cfg_rdata),
		.regs_o(cfg_regs)
	);

	// ---------------------------------------------------------------
	// address forms
	// ---------------------------------------------------------------
	assign real_addr = REAL_W'({SEG_VALUE_I, REAL_SHIFT'(0)}) +
		REAL_W'(ea_bus.offset_result[REAL_OFS_W-1:0]);
	assign lin_addr = SEG_BASE_I + ea_bus.offset_result;

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_comb
	begin
		n = s;
		n.done = 1'b0;
		case (s.st)
			ST_IDLE:
			begin
				n.ready = 1'b1;
				n.fault = 1'b0;
				n.overrun = 1'b0;
				if (REQ_VALID_I && s.ready)
				begin
					n.ready = 1'b0;
					n.wr = REQ_WR_I;
					n.size = REQ_SIZE_I;
					n.wdata = REQ_WDATA_I;
					n.ofs = ea_bus.offset_result;
					case (REQ_KIND_I)
						K_MEM:
						begin
							n.mio = 1'b1;
							if (ea_bus.index_bad)
							begin
								n.fault = 1'b1;
								n.done = 1'b1;
								n.ready = 1'b1;
							end
							else if (!PROT_MODE_I)
							begin
								n.addr = ADDR_W'(real_addr);
								if (real_addr[REAL_LIMIT_BIT])
								begin
									n.overrun = 1'b1;
									n.done = 1'b1;
									n.ready = 1'b1;
								end
								else
								begin
									n.cyc = 1'b1;
									n.st = ST_BUS;
								end
							end
							else if (PAGING_I)
							begin
								n.xreq = 1'b1;
								n.xlin = lin_addr;
								n.st = ST_XLATE;
							end
							else
							begin
								n.addr = lin_addr;
								n.cyc = 1'b1;
								n.st = ST_BUS;
							end
							n.be = lanes(REQ_SIZE_I, n.addr[1:0]);
						end
						K_IO:
						begin
							n.mio = 1'b0;
							n.addr = {IO_HIGH_ZERO, REQ_PORT_I};
							n.be = lanes(REQ_SIZE_I, REQ_PORT_I[1:0]);
							if (cfg_internal)
							begin
								n.rdata = {24'h000000, cfg_rdata};
								n.done = 1'b1;
								n.ready = 1'b1;
							end
							else
							begin
								n.cyc = 1'b1;
								n.st = ST_BUS;
							end
						end
						K_COP:
						begin
							n.mio = 1'b0;
							n.addr = COP_WIN_BASE +
								ADDR_W'(REQ_COP_OFS_I);
							n.be = lanes(REQ_SIZE_I, n.addr[1:0]);
							n.cyc = 1'b1;
							n.st = ST_BUS;
						end
						default:
						begin
							n.ready = 1'b1;
						end
					endcase
				end
			end
			ST_XLATE:
			begin
				if (XLATE_ACK_I)
				begin
					n.xreq = 1'b0;
					n.addr = XLATE_PHYS_I;
					n.be = lanes(s.size, XLATE_PHYS_I[1:0]);
					n.cyc = 1'b1;
					n.st = ST_BUS;
				end
			end
			ST_BUS:
			begin
				if (BUS_DONE_I)
				begin
					n.cyc = 1'b0;
					n.rdata = BUS_RDATA_I;
					n.done = 1'b1;
					n.ready = 1'b1;
					n.st = ST_IDLE;
				end
			end
			default:
			begin
				n = TOP_RST;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			s <= TOP_RST;
		end
		else
		begin
			s <= n;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign REQ_READY_O = s.ready;
	assign XLATE_REQ_O = s.xreq;
	assign XLATE_DIR_O = s.xlin[ADDR_W-1 -: PG_DIR_W];
	assign XLATE_TBL_O = s.xlin[PG_OFS_W +: PG_TBL_W];
	assign XLATE_OFS_O = s.xlin[PG_OFS_W-1:0];
	assign BUS_CYC_O = s.cyc;
	assign BUS_ADDR_O = s.addr;
	assign BUS_BE_O = s.be;
	assign BUS_MIO_O = s.mio;
	assign BUS_WR_O = s.wr;
	assign BUS_SIZE_O = s.size;
	assign BUS_WDATA_O = s.wdata;
	assign DONE_O = s.done;
	assign FAULT_O = s.fault;
	assign OVERRUN_O = s.overrun;
	assign RDATA_O = s.rdata;
	assign OFFSET_RESULT_O = s.ofs;
	assign CFG_REGS_O = cfg_regs;

endmodule : asg_top

// ===== core/asg_pkg.sv
// address generation package: port map, field widths, encodings
// assumes: compiled before every other design file
package asg_pkg;

	// ---------------------------------------------------------------
	// data path widths
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned GPR_N = 8;

	// ---------------------------------------------------------------
	// configuration ports and on-chip index window
	// ---------------------------------------------------------------
	localparam logic [15:0] CONFIG_INDEX_PORT = 16'h0022;
	localparam logic [15:0] CONFIG_DATA_PORT = 16'h0023;
	localparam logic [7:0] CFG_IDX_LO = 8'hc0;
	localparam logic [7:0] CFG_IDX_HI = 8'hcf;
	localparam int unsigned CFG_REG_N = 16;

	// ---------------------------------------------------------------
	// i/o space
	// ---------------------------------------------------------------
	localparam int unsigned IO_PORT_W = 16;
	localparam logic [ADDR_W-IO_PORT_W-1:0] IO_HIGH_ZERO = 16'h0000;
	localparam logic [31:0] COP_WIN_BASE = 32'h800000f8;
	localparam int unsigned COP_OFS_W = 3;

	// ---------------------------------------------------------------
	// offset and real mode fields
	// ---------------------------------------------------------------
	localparam logic [2:0] STACK_POINTER_REGISTER = 3'h4;
	localparam int unsigned SEG_W = 16;
	localparam int unsigned REAL_OFS_W = 16;
	localparam int unsigned REAL_SHIFT = 4;
	localparam int unsigned REAL_W = 21;
	localparam int unsigned REAL_LIMIT_BIT = 20;

	// ---------------------------------------------------------------
	// page translation split
	// ---------------------------------------------------------------
	localparam int unsigned PG_DIR_W = 10;
	localparam int unsigned PG_TBL_W = 10;
	localparam int unsigned PG_OFS_W = 12;

	// ---------------------------------------------------------------
	// encodings
	// ---------------------------------------------------------------
	typedef enum logic [3:0]
	{
		AM_DISP,
		AM_BASE,
		AM_BASE_DISP,
		AM_INDEX_DISP,
		AM_SCALED_DISP,
		AM_BASE_INDEX,
		AM_BASE_SCALED,
		AM_BASE_INDEX_DISP,
		AM_BASE_SCALED_DISP
	} asg_amode_t;

	typedef enum logic [1:0]
	{
		SZ_BYTE,
		SZ_WORD,
		SZ_DWORD
	} asg_size_t;

	typedef enum logic [1:0]
	{
		K_MEM,
		K_IO,
		K_COP
	} asg_kind_t;

endpackage : asg_pkg

// ===== core/asg_ea_if.sv
// carrier between the top and the offset adder
// assumes: asg_pkg compiled first
`timescale 1ns/1ps
interface asg_ea_if;
	import asg_pkg::*;

	logic [GPR_N-1:0][DATA_W-1:0] gpr;
	asg_amode_t amode;
	logic [2:0] base_sel;
	logic [2:0] index_sel;
	logic [1:0] index_multiplier;
	logic [ADDR_W-1:0] displacement_value;
	logic [ADDR_W-1:0] offset_result;
	logic index_bad;

	modport calc
	(
		input gpr, amode, base_sel, index_sel, index_multiplier,
		input displacement_value,
		output offset_result, index_bad
	);
	modport user
	(
		output gpr, amode, base_sel, index_sel, index_multiplier,
		output displacement_value,
		input offset_result, index_bad
	);
endinterface : asg_ea_if

// ===== core/asg_offset_calc.sv
// effective address adder: base + scaled index + displacement
// assumes: purely combinational, driven through asg_ea_if
`timescale 1ns/1ps
module asg_offset_calc
	import asg_pkg::*;
(
	// operand and result carrier
	asg_ea_if.calc ea
);

	// ---------------------------------------------------------------
	// mode decode: base, index, scale, displacement used
	// ---------------------------------------------------------------
	function automatic logic [3:0] am_terms(input asg_amode_t m);
		case (m)
			AM_DISP: am_terms = 4'h1;
			AM_BASE: am_terms = 4'h8;
			AM_BASE_DISP: am_terms = 4'h9;
			AM_INDEX_DISP: am_terms = 4'h5;
			AM_SCALED_DISP: am_terms = 4'h7;
			AM_BASE_INDEX: am_terms = 4'hc;
			AM_BASE_SCALED: am_terms = 4'he;
			AM_BASE_INDEX_DISP: am_terms = 4'hd;
			AM_BASE_SCALED_DISP: am_terms = 4'hf;
			default: am_terms = 4'h0;
		endcase
	endfunction : am_terms

	logic [3:0] terms;
	logic [ADDR_W-1:0] base_v;
	logic [ADDR_W-1:0] index_v;
	logic [ADDR_W-1:0] disp_v;

	always_comb
	begin
		terms = am_terms(ea.amode);
		base_v = terms[3] ? ea.gpr[ea.base_sel] : '0;
		index_v = terms[2] ? ea.gpr[ea.index_sel] : '0;
		if (terms[1])
		begin
			index_v = index_v << ea.index_multiplier;
		end
		disp_v = terms[0] ? ea.displacement_value : '0;
		ea.offset_result = base_v + index_v + disp_v;
		ea.index_bad = terms[2] &&
			(ea.index_sel == STACK_POINTER_REGISTER);
	end

endmodule : asg_offset_calc

// ===== core/asg_cfg_port.sv
// index/data configuration port pair with on-chip register bank
// assumes: acc_i is a one-cycle strobe of an accepted i/o access
`timescale 1ns/1ps
module asg_cfg_port
	import asg_pkg::*;
#(
	parameter int unsigned REG_N = CFG_REG_N
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// access being taken
	input wire logic acc_i,
	input wire logic wr_i,
	input wire logic [IO_PORT_W-1:0] port_i,
	input wire logic [7:0] wdata_i,
	// decision and read data
	output logic internal_o,
	output logic [7:0] rdata_o,
	output logic [REG_N-1:0][7:0] regs_o
);

	if (REG_N != 32'(CFG_IDX_HI - CFG_IDX_LO) + 1)
	begin : g_chk
		$error("register count must match the index window");
	end

	typedef struct packed
	{
		logic idx_valid;
		logic [7:0] index;
		logic [REG_N-1:0][7:0] regs;
	} asg_cfg_st_t;

	asg_cfg_st_t s;
	asg_cfg_st_t n;
	logic is_idx;
	logic is_dat;
	logic [3:0] slot;

	function automatic logic in_window(input logic [7:0] v);
		in_window = (v >= CFG_IDX_LO) && (v <= CFG_IDX_HI);
	endfunction : in_window

	always_comb
	begin
		n = s;
		is_idx = (port_i == CONFIG_INDEX_PORT);
		is_dat = (port_i == CONFIG_DATA_PORT);
		slot = 4'(s.index - CFG_IDX_LO);
		internal_o = (is_idx && wr_i && in_window(wdata_i)) ||
			(is_dat && s.idx_valid);
		rdata_o = s.regs[slot];
		if (acc_i)
		begin
			if (is_idx && wr_i)
			begin
				n.index = wdata_i;
				n.idx_valid = in_window(wdata_i);
			end
			else if (is_dat)
			begin
				n.idx_valid = 1'b0;
				if (s.idx_valid && wr_i)
				begin
					n.regs[slot] = wdata_i;
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

	assign regs_o = s.regs;

endmodule : asg_cfg_port

// ===== verif/asg_top_sva.sv
// checker: address steering and bus cycle relations at the top ports
// assumes: bound to asg_top, single clock with synchronous reset
`timescale 1ns/1ps
module asg_top_sva
	import asg_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	// request
	input wire logic REQ_VALID_I,
	input wire asg_kind_t REQ_KIND_I,
	input wire logic REQ_WR_I,
	input wire logic [DATA_W-1:0] REQ_WDATA_I,
	input wire logic [IO_PORT_W-1:0] REQ_PORT_I,
	input wire logic [COP_OFS_W-1:0] REQ_COP_OFS_I,
	input wire logic REQ_READY_O,
	input wire asg_amode_t AMODE_I,
	input wire logic [2:0] INDEX_SEL_I,
	// translation and bus
	input wire logic XLATE_REQ_O,
	input wire logic XLATE_ACK_I,
	input wire logic [ADDR_W-1:0] XLATE_PHYS_I,
	input wire logic BUS_CYC_O,
	input wire logic [ADDR_W-1:0] BUS_ADDR_O,
	input wire logic [3:0] BUS_BE_O,
	input wire logic BUS_MIO_O,
	input wire asg_size_t BUS_SIZE_O,
	// completion
	input wire logic DONE_O,
	input wire logic FAULT_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	logic take, idx_wr, in_win;
	assign take = REQ_VALID_I && REQ_READY_O;
	assign idx_wr = take && REQ_KIND_I == K_IO && REQ_WR_I
		&& REQ_PORT_I == CONFIG_INDEX_PORT;
	assign in_win = REQ_WDATA_I[7:0] >= CFG_IDX_LO
		&& REQ_WDATA_I[7:0] <= CFG_IDX_HI;

	sequence s_idx_hit;
		idx_wr && in_win;
	endsequence
	sequence s_idx_miss;
		idx_wr && !in_win;
	endsequence
	sequence s_xack;
		XLATE_REQ_O && XLATE_ACK_I;
	endsequence

	cop_window_a: assert property (take && REQ_KIND_I == K_COP |=> BUS_CYC_O
		&& !BUS_MIO_O
		&& BUS_ADDR_O == (COP_WIN_BASE | 32'($past(REQ_COP_OFS_I))))
		else $error("coprocessor cycle address wrong");
	io_addr_a: assert property (take && REQ_KIND_I == K_IO
		&& REQ_PORT_I[15:1] != 15'h0011 |=> BUS_CYC_O && !BUS_MIO_O
		&& BUS_ADDR_O == {16'h0000, $past(REQ_PORT_I)})
		else $error("port cycle address or select wrong");
	idx_hit_a: assert property (s_idx_hit |=> DONE_O && !BUS_CYC_O)
		else $error("index hit made a bus cycle");
	idx_miss_a: assert property (s_idx_miss |=> BUS_CYC_O)
		else $error("index miss stayed internal");
	idx_read_a: assert property (take && REQ_KIND_I == K_IO && !REQ_WR_I
		&& REQ_PORT_I == CONFIG_INDEX_PORT |=> BUS_CYC_O)
		else $error("index read stayed internal");
	sp_fault_a: assert property (take && REQ_KIND_I == K_MEM
		&& AMODE_I >= AM_INDEX_DISP && AMODE_I <= AM_BASE_SCALED_DISP
		&& INDEX_SEL_I == STACK_POINTER_REGISTER
		|=> DONE_O && FAULT_O && !BUS_CYC_O)
		else $error("stack pointer index not refused");
	xlate_use_a: assert property (s_xack |=> BUS_CYC_O && !XLATE_REQ_O
		&& BUS_ADDR_O == $past(XLATE_PHYS_I))
		else $error("translated address not used");
	lane_mask_a: assert property (BUS_CYC_O |-> BUS_BE_O == 4'(
		(BUS_SIZE_O == SZ_BYTE ? 4'h1 : BUS_SIZE_O == SZ_WORD ? 4'h3
		: 4'hf) << BUS_ADDR_O[1:0]))
		else $error("byte lanes wrong");
endmodule : asg_top_sva

bind asg_top asg_top_sva u_sva (.*);

// ===== verif/asg_bus_model.sv
// partner: system bus devices and page translation answerer
// assumes: same clock as the design, answers with pulses
`timescale 1ns/1ps
module asg_bus_model
(
	// clock, reset and slow answer select
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	// bus
	input wire logic cyc_i,
	input wire logic [31:0] addr_i,
	output logic done_o,
	output logic [31:0] rdata_o,
	// translation
	input wire logic xreq_i,
	input wire logic [9:0] dir_i,
	input wire logic [9:0] tbl_i,
	input wire logic [11:0] ofs_i,
	output logic xack_o,
	output logic [31:0] xphys_o
);
	logic [2:0] cnt, xcnt;
	logic go, xgo;
	assign go = cyc_i && !done_o && cnt >= (slow_i ? 3'h3 : 3'h0);
	assign xgo = xreq_i && !xack_o && xcnt >= 3'h1;
	always @(posedge clk_i)
		if (rst_i)
		begin
			{cnt, xcnt, done_o, xack_o} <= '0;
			{rdata_o, xphys_o} <= '0;
		end
		else
		begin
			cnt <= cyc_i && !done_o ? cnt + 3'h1 : 3'h0;
			xcnt <= xreq_i && !xack_o ? xcnt + 3'h1 : 3'h0;
			done_o <= go;
			xack_o <= xgo;
			rdata_o <= go ? ~addr_i : ~rdata_o;
			xphys_o <= xgo ? {{dir_i, tbl_i} ^ 20'h0f0f0, ofs_i}
				: ~xphys_o;
		end
endmodule : asg_bus_model

// ===== verif/tb.sv
// testbench: requests through the top, checks addresses and steering
// assumes: package, design, checker and partner compiled first
`timescale 1ns/1ps
module tb;
	import asg_pkg::*;

	localparam logic [8:0] BM = 9'b111100110;
	localparam logic [8:0] IM = 9'b111111000;
	localparam logic [8:0] SM = 9'b101010000;
	localparam logic [8:0] DM = 9'b110011101;
	logic clk = 1'b0, rst = 1'b1, prot = 1'b0, pg = 1'b0, vld = 1'b0;
	logic wr = 1'b0, slow = 1'b0;
	asg_kind_t kind = K_MEM;
	asg_size_t sz = SZ_DWORD;
	asg_amode_t am = AM_DISP;
	logic [31:0] wd = 32'h0, disp = 32'h0, sb = 32'h0, lba, lin;
	logic [15:0] port = 16'h0, seg = 16'h0;
	logic [2:0] cop = 3'h0, bs = 3'h3, ix = 3'h5;
	logic [1:0] mul = 2'h0;
	logic [7:0][31:0] gpr = '0;
	logic rdy, xreq, xack, cyc, mio, bdone, done, flt, ovr, lmio;
	logic bwr, lwr;
	asg_size_t bsz, lsz;
	logic [9:0] xd, xt;
	logic [11:0] xo;
	logic [31:0] xph, ba, brd, rd, ofs, bwd, lwd;
	logic [3:0] be;
	logic [127:0] cfg;
	int fails = 0, comparisons = 0, ncyc = 0, n0 = 0, tick = 0;

	asg_top u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PROT_MODE_I(prot),
		.PAGING_I(pg), .REQ_VALID_I(vld), .REQ_KIND_I(kind), .REQ_WR_I(wr),
		.REQ_SIZE_I(sz), .REQ_WDATA_I(wd), .REQ_PORT_I(port),
		.REQ_COP_OFS_I(cop), .REQ_READY_O(rdy), .GPR_FILE_I(gpr),
		.AMODE_I(am), .BASE_SEL_I(bs), .INDEX_SEL_I(ix),
		.INDEX_MULTIPLIER_I(mul), .DISPLACEMENT_VALUE_I(disp),
		.SEG_VALUE_I(seg), .SEG_BASE_I(sb), .XLATE_REQ_O(xreq),
		.XLATE_DIR_O(xd), .XLATE_TBL_O(xt), .XLATE_OFS_O(xo),
		.XLATE_ACK_I(xack), .XLATE_PHYS_I(xph), .BUS_CYC_O(cyc),
		.BUS_ADDR_O(ba), .BUS_BE_O(be), .BUS_MIO_O(mio), .BUS_WR_O(bwr),
		.BUS_SIZE_O(bsz), .BUS_WDATA_O(bwd), .BUS_DONE_I(bdone),
		.BUS_RDATA_I(brd), .DONE_O(done), .FAULT_O(flt), .OVERRUN_O(ovr),
		.RDATA_O(rd), .OFFSET_RESULT_O(ofs), .CFG_REGS_O(cfg));
	asg_bus_model u_bus (.clk_i(clk), .rst_i(rst), .slow_i(slow),
		.cyc_i(cyc), .addr_i(ba), .done_o(bdone), .rdata_o(brd),
		.xreq_i(xreq), .dir_i(xd), .tbl_i(xt), .ofs_i(xo), .xack_o(xack),
		.xphys_o(xph));

	always #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		tick++;
		if (cyc && bdone)
		begin
			ncyc++;
			lba = ba;
			lmio = mio;
			lwr = bwr;
			lwd = bwd;
			lsz = bsz;
		end
		if (tick == 3000)
		begin
			fails++;
			tally_and_finish();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task op(input asg_kind_t k, input logic w, input asg_size_t s,
		input logic [15:0] p);
		n0 = ncyc;
		kind <= k;
		wr <= w;
		sz <= s;
		port <= p;
		vld <= 1'b1;
		@(posedge clk);
		while (!rdy) @(posedge clk);
		vld <= 1'b0;
		@(posedge clk);
		while (!done) @(posedge clk);
	endtask : op

	task io(input asg_kind_t k, input logic w, input asg_size_t s,
		input logic [15:0] p, input logic [7:0] d, input int ext);
		wd <= {24'h0, d};
		op(k, w, s, p);
		chk(ncyc - n0, ext);
		if (ext == 1)
		begin
			chk(lba, k == K_COP ? COP_WIN_BASE | cop : {16'h0, p});
			chk(lmio, 32'h0);
			chk(lwr, w);
			chk(lsz, s);
			chk(lwd, {24'h0, d});
		end
	endtask : io

	task rm(input logic [15:0] s, input logic [15:0] d, input logic [31:0] e);
		seg <= s;
		disp <= {16'h0, d};
		op(K_MEM, 1'b0, SZ_BYTE, 16'h0);
		chk(ovr, e[20]);
		chk(ncyc - n0, !e[20]);
		if (!e[20])
			chk(lba, e);
	endtask : rm

	function automatic logic [31:0] ea(input int m, input logic [1:0] s);
		ea = (BM[m] ? gpr[3] : 32'h0) + (DM[m] ? disp : 32'h0)
			+ (IM[m] ? gpr[5] << (SM[m] ? s : 2'h0) : 32'h0);
	endfunction : ea

	task tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		for (int k = 0; k < 8; k++)
			gpr[k] = 32'h1000_0001 * (k + 1);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		prot <= 1'b1;
		sb <= 32'h2000_0000;
		disp <= 32'hffff_fff0;
		for (int k = 0; k < 18; k++)
		begin
			am <= asg_amode_t'(k % 9);
			mul <= 2'(k % 9 % 4 + k / 9);
			slow <= 1'(k);
			op(K_MEM, 1'b0, SZ_DWORD, 16'h0);
			chk(ofs, ea(k % 9, mul));
			chk(lba, sb + ea(k % 9, mul));
			chk(rd, ~lba);
		end
		pg <= 1'b1;
		am <= AM_BASE_DISP;
		op(K_MEM, 1'b0, SZ_DWORD, 16'h0);
		lin = sb + ea(2, 2'h0);
		chk(lba, {lin[31:12] ^ 20'h0f0f0, lin[11:0]});
		pg <= 1'b0;
		am <= AM_BASE_INDEX;
		ix <= 3'h4;
		op(K_MEM, 1'b0, SZ_DWORD, 16'h0);
		chk(flt, 32'h1);
		chk(ncyc - n0, 32'h0);
		ix <= 3'h5;
		prot <= 1'b0;
		am <= AM_DISP;
		rm(16'h1234, 16'h0010, 32'h0001_2350);
		rm(16'hf000, 16'hffff, 32'h000f_ffff);
		rm(16'hffff, 16'h0010, 32'h0010_0000);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0080, 8'h0, 1);
		io(K_IO, 1'b0, SZ_WORD, 16'h1232, 8'h0, 1);
		io(K_IO, 1'b0, SZ_DWORD, 16'hfffc, 8'h0, 1);
		cop <= 3'h5;
		io(K_COP, 1'b0, SZ_DWORD, 16'h0, 8'h0, 1);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0022, 8'hc3, 0);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0023, 8'h5a, 0);
		chk(cfg[31:24], 32'h5a);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0023, 8'h77, 1);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0022, 8'hb0, 1);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0023, 8'h11, 1);
		io(K_IO, 1'b0, SZ_BYTE, 16'h0022, 8'h0, 1);
		chk(cfg[31:24], 32'h5a);
		io(K_IO, 1'b1, SZ_BYTE, 16'h0022, 8'hc3, 0);
		io(K_IO, 1'b0, SZ_BYTE, 16'h0023, 8'h0, 0);
		chk(rd, 32'h5a);
		tally_and_finish();
	end
endmodule : tb
